// File: hw/cfg_hdr_pkg.sv
/*
 * Constants, field positions and carrier types for the configuration
 * status and identification register slice.
 * Assumes byte offsets from the configuration decoder, dword aligned.
 */
package cfg_hdr_pkg;

	localparam logic [7:0]  OFS_CMD_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_STATUS       = 8'h06;
	localparam logic [7:0]  OFS_REV_CLASS    = 8'h08;
	localparam logic [7:0]  OFS_REVISION     = 8'h08;
	localparam logic [7:0]  OFS_CLASS        = 8'h09;
	localparam logic [7:0]  OFS_CACHE_LINE   = 8'h0c;

	localparam int          BIT_PARITY       = 15;
	localparam int          BIT_SYSTEM_ERROR = 14;
	localparam int          BIT_MASTER_ABORT = 13;
	localparam int          BIT_TABORT_RX    = 12;
	localparam int          BIT_TABORT_TX    = 11;
	localparam int          BIT_MDATA_PAR    = 8;
	localparam int          CMD_BIT_PAR_RESP = 6;
	localparam int          CMD_BIT_SYS_DRV  = 8;

	localparam logic [1:0]  DEVSEL_MEDIUM    = 2'h1;
	localparam logic        B2B_VALUE        = 1'b0;
	localparam logic        USER_FEAT_VALUE  = 1'b0;
	localparam logic        HS_VALUE         = 1'b0;
	localparam logic        CAP_LIST_VALUE   = 1'b1;
	localparam logic [3:0]  RSVD_VALUE       = 4'h0;

	localparam logic [15:0] STATUS_RC_MASK   = 16'hf900;
	localparam logic [7:0]  CACHE_LINE_RESET = 8'h00;
	localparam logic [23:0] CLASS_CODE       = 24'h060700;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic        addr_parity;
		logic        data_parity;
		logic        signaled_system_error_flag;
		logic        master_abort;
		logic        target_abort_rx;
		logic        target_abort_tx;
		logic        perr_seen;
		logic        was_master;
	} bus_event_s;

endpackage

// File: hw/cfg_status_ident_regs.sv
/*
 * Status, revision, class code and cache line size registers of the
 * configuration header, reached by configuration accesses.
 * Assumes the bus interface decodes configuration cycles into cfg_req,
 * supplies command bits 8 and 6 and pulses the bus event inputs.
 */
// Functional notes
// (RULE_01) Set status bit 15 on any detected address or data parity error.
// (RULE_02) Set status bit 14 when system error is enabled and signalled.
// (RULE_03) Set status bit 13 when our master cycle ends in master abort.
// (RULE_04) Set status bit 12 when our master cycle is target aborted.
// (RULE_05) Set status bit 11 when we end a transaction with target abort.
// (RULE_06) Status bits 10 to 9 read fixed 01, medium select timing.
// (RULE_07) Set bit 8 on parity error seen while master with parity response on.
// (RULE_08) Status bit 7 reads zero, no fast back-to-back.
// (RULE_09) Status bit 6 reads zero, no user-definable features.
// (RULE_10) Status bit 5 reads zero, not high speed capable.
// (RULE_11) Status bit 4 reads one, capability list present.
// (RULE_12) Status bits 3 to 0 read zero.
// (RULE_13) Read-only revision byte at 08h, writes ignored.
// (RULE_14) Read-only class code at 09h reads 060700h.
// (RULE_15) Read/write cache line size byte at 0Ch, resets to 00h.
// (RULE_16) Writing one clears only that status bit; zero leaves it.
// (RULE_17) Command bit 8 enables error driver; address parity needs bits 8 and 6.
// (RULE_18) Hardware set wins over a same-cycle write-one clear.
module cfg_status_ident_regs #(
	parameter logic [7:0] SILICON_REV = 8'h01  // Arbitrary value
) (
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire cfg_hdr_pkg::cfg_req_s   cfg_req,
	input  wire logic                    system_error_enable,
	input  wire logic                    parity_response_enable,
	input  wire cfg_hdr_pkg::bus_event_s bus_event,
	output logic [31:0]                  cfg_rdata,
	output logic                         cfg_rvalid,
	output logic                         system_error_out,
	output logic [15:0]                  bus_status_flags
);
	import cfg_hdr_pkg::*;

	logic        rst_meta_reg;
	logic        rst_sync_n_reg;
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic [7:0]  cache_line_length_reg;
	logic [7:0]  cache_line_length_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic        serr_reg;
	logic        serr_next;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] status_view;
	logic        addr_perr_report;

	function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
		hits = (addr[7:2] == ofs[7:2]);
	endfunction

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	always_comb
	begin
		addr_perr_report = bus_event.addr_parity & system_error_enable
			& parity_response_enable; // RULE_17
		set_vec = 16'h0000;
		set_vec[BIT_PARITY]    = bus_event.addr_parity | bus_event.data_parity; // RULE_01
		set_vec[BIT_SYSTEM_ERROR] = system_error_enable
			& (bus_event.signaled_system_error_flag | addr_perr_report); // RULE_02
		set_vec[BIT_MASTER_ABORT] = bus_event.master_abort; // RULE_03
		set_vec[BIT_TABORT_RX] = bus_event.target_abort_rx; // RULE_04
		set_vec[BIT_TABORT_TX] = bus_event.target_abort_tx; // RULE_05
		set_vec[BIT_MDATA_PAR] = bus_event.perr_seen & bus_event.was_master
			& parity_response_enable; // RULE_07
		clr_vec = 16'h0000;
		if (cfg_req.wr && hits(cfg_req.addr, OFS_STATUS))
		begin
			clr_vec = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}}
				& cfg_req.wdata[31:16] & STATUS_RC_MASK; // RULE_16
		end
		flags_next = ((flags_reg & ~clr_vec) | set_vec) & STATUS_RC_MASK; // RULE_18
		serr_next  = set_vec[BIT_SYSTEM_ERROR]; // RULE_17
	end

	always_comb
	begin
		status_view = flags_reg;
		status_view[10:9] = DEVSEL_MEDIUM; // RULE_06
		status_view[7]    = B2B_VALUE; // RULE_08
		status_view[6]    = USER_FEAT_VALUE; // RULE_09
		status_view[5]    = HS_VALUE; // RULE_10
		status_view[4]    = CAP_LIST_VALUE; // RULE_11
		status_view[3:0]  = RSVD_VALUE; // RULE_12
	end

	always_comb
	begin
		cache_line_length_next = cache_line_length_reg;
		if (cfg_req.wr && cfg_req.be[0] && hits(cfg_req.addr, OFS_CACHE_LINE))
		begin
			cache_line_length_next = cfg_req.wdata[7:0]; // RULE_15
		end
		rvalid_next = cfg_req.rd;
		rdata_next  = 32'h0000_0000;
		if (cfg_req.rd)
		begin
			if (hits(cfg_req.addr, OFS_CMD_STATUS))
			begin
				rdata_next = {status_view, 16'h0000};
			end
			else if (hits(cfg_req.addr, OFS_REV_CLASS))
			begin
				rdata_next = {CLASS_CODE, SILICON_REV}; // RULE_13 RULE_14
			end
			else if (hits(cfg_req.addr, OFS_CACHE_LINE))
			begin
				rdata_next = {24'h00_0000, cache_line_length_reg};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n_reg)
	begin
		if (!rst_sync_n_reg)
		begin
			flags_reg             <= 16'h0000;
			cache_line_length_reg <= CACHE_LINE_RESET;
			rdata_reg             <= 32'h0000_0000;
			rvalid_reg            <= 1'b0;
			serr_reg              <= 1'b0;
		end
		else
		begin
			flags_reg             <= flags_next;
			cache_line_length_reg <= cache_line_length_next;
			rdata_reg             <= rdata_next;
			rvalid_reg            <= rvalid_next;
			serr_reg              <= serr_next;
		end
	end

	assign cfg_rdata        = rdata_reg;
	assign cfg_rvalid       = rvalid_reg;
	assign system_error_out = serr_reg;
	assign bus_status_flags = status_view;

endmodule

// File: verification/cfg_status_ident_regs_sva.sv
/* Assertions on the status slice ports.
   Assumes one clk_sys domain and nrst as its reset. */
module cfg_status_ident_regs_sva (
	input wire logic                    clk_sys,
	input wire logic                    nrst,
	input wire cfg_hdr_pkg::cfg_req_s   cfg_req,
	input wire logic                    system_error_enable,
	input wire logic                    parity_response_enable,
	input wire cfg_hdr_pkg::bus_event_s bus_event,
	input wire logic [31:0]             cfg_rdata,
	input wire logic                    cfg_rvalid,
	input wire logic                    system_error_out,
	input wire logic [15:0]             bus_status_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_hdr_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_fix; {bus_status_flags[10:9], bus_status_flags[7:0]} == 10'h110; endproperty
	a_fix: assert property (p_fix) else $error("fixed bits");
	property p_par; bus_event.data_parity |=> bus_status_flags[15]; endproperty
	a_par: assert property (p_par) else $error("parity flag");
	property p_ma; bus_event.master_abort |=> bus_status_flags[13]; endproperty
	a_ma: assert property (p_ma) else $error("abort flag");
	property p_dp; bus_event.perr_seen && bus_event.was_master && parity_response_enable
		|=> bus_status_flags[8]; endproperty
	a_dp: assert property (p_dp) else $error("data parity flag");
	property p_se; bus_event.signaled_system_error_flag && system_error_enable
		|=> system_error_out && bus_status_flags[14]; endproperty
	a_se: assert property (p_se) else $error("system error");
	property p_nse; !system_error_enable |=> !system_error_out; endproperty
	a_nse: assert property (p_nse) else $error("error driver");
	property p_rv; cfg_req.rd |=> cfg_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read valid");
	property p_cls; cfg_req.rd && cfg_req.addr[7:2] == 6'h02
		|=> cfg_rdata[31:8] == CLASS_CODE; endproperty
	a_cls: assert property (p_cls) else $error("class code");
	property p_keep; bus_status_flags[13] && !(cfg_req.wr && cfg_req.wdata[29])
		|=> bus_status_flags[13]; endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
endmodule
bind cfg_status_ident_regs cfg_status_ident_regs_sva u_sva (.clk_sys, .nrst, .cfg_req,
	.system_error_enable, .parity_response_enable, .bus_event, .cfg_rdata, .cfg_rvalid,
	.system_error_out, .bus_status_flags);

// File: verification/cfg_host.sv
/* Host model issuing configuration reads and writes.
   Assumes one request per access, read data one cycle later. */
module cfg_host (
	input  wire logic               clk_sys,
	output cfg_hdr_pkg::cfg_req_s   req,
	input  wire logic [31:0]        rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_hdr_pkg::*;
	initial req = '0;
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys) #1 req = '{~w, w, a, b, d};
		@(posedge clk_sys) #1 req = '{1'b0, 1'b0, ~a, ~b, ~d};
		q = rdata;
	endtask
endmodule

// File: verification/test_cfg_status_ident_regs.sv
/* Bench for the status and identification registers.
   Assumes the default revision parameter. */
module test_cfg_status_ident_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_hdr_pkg::*;
	logic clk_sys = 0, nrst = 0, system_error_enable = 0, parity_response_enable = 0, s;
	bus_event_s bus_event = '0;
	cfg_req_s cfg_req;
	logic [31:0] cfg_rdata, q;
	logic cfg_rvalid, system_error_out;
	logic [15:0] bus_status_flags;
	int fails = 0, compares = 0, cyc = 0;
	always #4 clk_sys = ~clk_sys;
	cfg_status_ident_regs u_cfg_status_ident_regs (.clk_sys, .nrst, .cfg_req,
		.system_error_enable, .parity_response_enable, .bus_event, .cfg_rdata,
		.cfg_rvalid, .system_error_out, .bus_status_flags);
	cfg_host u_cfg_host (.clk_sys(clk_sys), .req(cfg_req), .rdata(cfg_rdata));
	task automatic end_sim;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		u_cfg_host.acc(1'b1, a, b, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		u_cfg_host.acc(1'b0, a, 4'hf, 32'h0, q);
		chk(q, e);
		chk({31'h0, cfg_rvalid}, 32'h1);
	endtask
	task automatic ev(input logic [7:0] e);
		@(posedge clk_sys) #1 bus_event = e;
		@(posedge clk_sys) #1 bus_event = '0;
		s = system_error_out;
	endtask
	always @(posedge clk_sys)
		if (++cyc == 1000)
		begin
			fails++;
			end_sim();
		end
	initial
	begin
		repeat (2) @(posedge clk_sys);
		#1 nrst = 1;
		repeat (3) @(posedge clk_sys);
		rd(8'h04, 32'h0210_0000);
		wr(8'h08, 4'hf, 32'hffff_ffff);
		rd(8'h08, 32'h0607_0001);
		rd(8'h0c, 32'h0);
		wr(8'h0c, 4'h1, 32'hffff_ffa5);
		rd(8'h0c, 32'ha5);
		ev(8'h03);
		chk({s, bus_status_flags}, 32'h0210);
		ev(8'h20);
		chk({s, bus_status_flags}, 32'h0210);
		parity_response_enable = 1;
		system_error_enable = 1;
		ev(8'h7f);
		chk({s, bus_status_flags}, 32'h1fb10);
		wr(8'h06, 4'hc, 32'h2000_0000);
		chk(bus_status_flags, 32'hdb10);
		fork
			wr(8'h06, 4'hc, 32'h2000_0000);
			ev(8'h10);
		join
		chk(bus_status_flags, 32'hfb10);
		wr(8'h06, 4'hc, 32'hffff_0000);
		chk(bus_status_flags, 32'h0210);
		ev(8'h80);
		chk({s, bus_status_flags}, 32'h1c210);
		end_sim();
	end
endmodule
